// file: rtl/plt_pkg.sv
package plt_pkg;
    // Control line codes
    localparam logic [1:0] CODE_IDLE = 2'h0;
    localparam logic [1:0] CODE_HOLD = 2'h1;
    localparam logic [1:0] CODE_TX = 2'h2;
    localparam logic [1:0] CODE_GRANT = 2'h3;

    // Speed classes
    localparam logic [1:0] SPD_100 = 2'h0;
    localparam logic [1:0] SPD_200 = 2'h1;
    localparam logic [1:0] SPD_400 = 2'h2;
    localparam logic [1:0] SPD_BAD = 2'h3;

    // Speed code patterns on the data lines
    localparam logic [1:0] SC100_TOP2 = 2'h0;
    localparam logic [3:0] SC200_TOP4 = 4'h4;
    localparam logic [7:0] SC400_FULL = 8'h50;

    // Link behaviour limits
    localparam int MAX_HOLD = 47;
    localparam int CANCEL_IDLES_NO_HOLD = 3;
    localparam int CANCEL_IDLES_AFTER_HOLD = 2;
    localparam int MIN_PHY_IDLE = 1;
    // Cycles the pin synchroniser still echoes our own drive after hand-over
    localparam int SYNC_LAG = 2;

    typedef enum logic [2:0] {
        ST_PHY = 3'b000,
        ST_GRANT = 3'b001,
        ST_HAND = 3'b010,
        ST_PRE = 3'b011,
        ST_DATA = 3'b100,
        ST_TERM = 3'b101,
        ST_BACK = 3'b110
    } plt_state_e;
endpackage : plt_pkg

// file: rtl/plt_spd_if.sv
`timescale 1ns/1ns
interface plt_spd_if;
    logic [7:0] code;
    logic [1:0] speed;
    modport dec (input code, output speed);
    modport user (output code, input speed);
endinterface : plt_spd_if

// file: rtl/plt_spd_dec.sv
`timescale 1ns/1ns
module plt_spd_dec (
    plt_spd_if.dec spd
);
    // Don't-care bits are ignored; data-on and other patterns are invalid
    wire is100 = spd.code[7:6] == plt_pkg::SC100_TOP2;
    wire is200 = spd.code[7:4] == plt_pkg::SC200_TOP4;
    wire is400 = spd.code == plt_pkg::SC400_FULL;
    assign spd.speed = is100 ? plt_pkg::SPD_100 :
                       is200 ? plt_pkg::SPD_200 :
                       is400 ? plt_pkg::SPD_400 : plt_pkg::SPD_BAD;
endmodule : plt_spd_dec

// file: rtl/plt_phy_tx.sv
`timescale 1ns/1ns
module plt_phy_tx #(
    parameter int HOLD_LIMIT = plt_pkg::MAX_HOLD
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic grant_req,
    input wire logic [1:0] first_speed,
    input wire logic multispeed_concat_enable,
    input wire logic [1:0] interface_control_lines_in,
    input wire logic [7:0] data_lines_in,
    output logic [1:0] interface_control_lines_out,
    output logic interface_control_lines_oe,
    output logic [7:0] data_lines_out,
    output logic data_lines_oe,
    output logic grant_busy,
    output logic link_owner,
    output logic tx_start,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic concat_req,
    output logic bus_release,
    output logic tx_cancel,
    output logic [1:0] tx_speed,
    output logic proto_err
);
    // ==========================================================
    // Elaboration checks
    if (HOLD_LIMIT < 1 || HOLD_LIMIT > 63) begin : g_bad_limit
        $error("HOLD_LIMIT must be 1..63");
    end

    // ==========================================================
    // Pin synchronisers
    // Link is on our clock, but the pins are still treated as foreign
    logic [1:0] code_s1_ff;
    logic [1:0] code_s2_ff;
    logic [7:0] d_s1_ff;
    logic [7:0] d_s2_ff;
    always_ff @(posedge core_clk) begin
        code_s1_ff <= interface_control_lines_in;
        code_s2_ff <= code_s1_ff;
        d_s1_ff <= data_lines_in;
        d_s2_ff <= d_s1_ff;
    end

    // ==========================================================
    // Speed decode
    plt_spd_if spd ();
    assign spd.code = d_s2_ff;
    plt_spd_dec u_dec (
        .spd(spd)
    );

    // ==========================================================
    // State
    plt_pkg::plt_state_e state_ff;
    plt_pkg::plt_state_e nxt_state;
    logic [5:0] hold_cnt_ff;
    logic [1:0] idle_cnt_ff;
    logic [5:0] nxt_hold_cnt;
    logic [1:0] nxt_idle_cnt;
    logic [1:0] nxt_speed;
    logic [1:0] skip_cnt_ff;
    logic [1:0] nxt_skip_cnt;
    // Concatenation pending keeps the speed in force after the terminating hold, taken from it or not
    logic concat_req_pend_ff;

    wire c_idle = code_s2_ff == plt_pkg::CODE_IDLE;
    wire c_hold = code_s2_ff == plt_pkg::CODE_HOLD;
    wire c_tx = code_s2_ff == plt_pkg::CODE_TX;
    wire c_grant = code_s2_ff == plt_pkg::CODE_GRANT;
    wire in_pre = state_ff == plt_pkg::ST_PRE;
    // Synchroniser still shows our own grant and idle, so ignore them
    wire pre_live = in_pre && skip_cnt_ff == 2'h0;
    wire in_data = state_ff == plt_pkg::ST_DATA;
    wire in_term = state_ff == plt_pkg::ST_TERM;

    // Cancellation: two idles after holds, or three with no hold
    wire need2 = hold_cnt_ff != 6'h00;
    wire cancel_done = pre_live && c_idle &&
        (need2 ? idle_cnt_ff == 2'(plt_pkg::CANCEL_IDLES_AFTER_HOLD - 1)
               : idle_cnt_ff == 2'(plt_pkg::CANCEL_IDLES_NO_HOLD - 1));
    // More than one leading idle followed by hold or transmit
    wire lead_bad = pre_live && !c_idle && !need2 && idle_cnt_ff > 2'h1;
    wire hold_bad = pre_live && c_hold && hold_cnt_ff >= 6'(HOLD_LIMIT);
    wire hold_after_idle = pre_live && c_hold && need2 && idle_cnt_ff != 2'h0;
    wire term_hold = in_data && c_hold;
    wire term_idle = in_data && c_idle;
    wire term_bad = in_term && !c_idle;
    wire grant_bad = (pre_live || in_data) && c_grant;
    wire err = lead_bad || hold_bad || hold_after_idle || term_bad || grant_bad;

    // Next speed: captured from terminating hold only when enabled
    wire spd_ok = spd.speed != plt_pkg::SPD_BAD;
    wire spd_down = spd.speed == plt_pkg::SPD_100 && tx_speed != plt_pkg::SPD_100;
    wire take_spd = term_hold && multispeed_concat_enable && spd_ok && !spd_down;
    wire spd_err = term_hold && multispeed_concat_enable && (!spd_ok || spd_down);

    always_comb begin
        nxt_state = state_ff;
        nxt_hold_cnt = hold_cnt_ff;
        nxt_idle_cnt = idle_cnt_ff;
        nxt_skip_cnt = skip_cnt_ff;
        case (state_ff)
            plt_pkg::ST_PHY: begin
                if (grant_req) begin
                    nxt_state = plt_pkg::ST_GRANT;
                end
            end
            plt_pkg::ST_GRANT: nxt_state = plt_pkg::ST_HAND;
            plt_pkg::ST_HAND: begin
                nxt_state = plt_pkg::ST_PRE;
                nxt_hold_cnt = 6'h00;
                nxt_idle_cnt = 2'h0;
                nxt_skip_cnt = 2'(plt_pkg::SYNC_LAG);
            end
            plt_pkg::ST_PRE: begin
                if (skip_cnt_ff != 2'h0) begin
                    nxt_skip_cnt = skip_cnt_ff - 2'h1;
                end else if (c_tx) begin
                    nxt_state = plt_pkg::ST_DATA;
                end else if (cancel_done || err) begin
                    nxt_state = plt_pkg::ST_BACK;
                end else if (c_hold) begin
                    nxt_hold_cnt = hold_cnt_ff + 6'h01;
                    nxt_idle_cnt = 2'h0;
                end else if (c_idle) begin
                    nxt_idle_cnt = idle_cnt_ff + 2'h1;
                end
            end
            plt_pkg::ST_DATA: begin
                if (term_hold || term_idle) begin
                    nxt_state = plt_pkg::ST_TERM;
                end else if (grant_bad) begin
                    nxt_state = plt_pkg::ST_BACK;
                end
            end
            plt_pkg::ST_TERM: nxt_state = plt_pkg::ST_BACK;
            plt_pkg::ST_BACK: nxt_state = plt_pkg::ST_PHY;
            default: nxt_state = plt_pkg::ST_PHY;
        endcase
    end

    // Speed bookkeeping outside the state machine
    always_comb begin
        nxt_speed = tx_speed;
        if (state_ff == plt_pkg::ST_PHY && grant_req && !concat_req_pend_ff) begin
            nxt_speed = first_speed;
        end else if (take_spd) begin
            nxt_speed = spd.speed;
        end
    end

    // ==========================================================
    // Pin drive
    // PHY drives only grant, hand-over idle and its own idle time
    wire phy_drives = nxt_state == plt_pkg::ST_PHY || nxt_state == plt_pkg::ST_GRANT ||
                      nxt_state == plt_pkg::ST_HAND || nxt_state == plt_pkg::ST_BACK;
    wire [1:0] nxt_code = nxt_state == plt_pkg::ST_GRANT ? plt_pkg::CODE_GRANT
                                                          : plt_pkg::CODE_IDLE;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= plt_pkg::ST_PHY;
            hold_cnt_ff <= 6'h00;
            idle_cnt_ff <= 2'h0;
            skip_cnt_ff <= 2'h0;
            interface_control_lines_out <= plt_pkg::CODE_IDLE;
            interface_control_lines_oe <= 1'b1;
            data_lines_out <= 8'h00;
            data_lines_oe <= 1'b1;
            grant_busy <= 1'b0;
            link_owner <= 1'b0;
            tx_start <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            concat_req <= 1'b0;
            concat_req_pend_ff <= 1'b0;
            bus_release <= 1'b0;
            tx_cancel <= 1'b0;
            tx_speed <= plt_pkg::SPD_100;
            proto_err <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            hold_cnt_ff <= nxt_hold_cnt;
            idle_cnt_ff <= nxt_idle_cnt;
            skip_cnt_ff <= nxt_skip_cnt;
            interface_control_lines_out <= nxt_code;
            interface_control_lines_oe <= phy_drives;
            data_lines_out <= 8'h00;
            data_lines_oe <= phy_drives;
            grant_busy <= nxt_state == plt_pkg::ST_GRANT || nxt_state == plt_pkg::ST_HAND;
            link_owner <= !phy_drives;
            tx_start <= pre_live && c_tx;
            tx_valid <= (pre_live || in_data) && c_tx;
            tx_data <= c_tx ? d_s2_ff : 8'h00;
            concat_req <= term_hold;
            if (term_hold) begin
                concat_req_pend_ff <= 1'b1;
            end else if (term_idle || cancel_done) begin
                concat_req_pend_ff <= 1'b0;
            end
            bus_release <= term_idle || cancel_done;
            tx_cancel <= cancel_done;
            tx_speed <= nxt_speed;
            proto_err <= err || spd_err;
        end
    end
endmodule : plt_phy_tx

// file: sim/plt_phy_tx_props.sv
`timescale 1ns/1ns
// ==========
// Hand-over, transmit and termination checks
module plt_phy_tx_props (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic grant_req,
    input wire logic [1:0] interface_control_lines_in,
    input wire logic [7:0] data_lines_in,
    input wire logic [1:0] interface_control_lines_out,
    input wire logic interface_control_lines_oe,
    input wire logic data_lines_oe,
    input wire logic grant_busy,
    input wire logic link_owner,
    input wire logic tx_start,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic concat_req,
    input wire logic bus_release
);
    wire logic [1:0] ci = interface_control_lines_in;
    wire logic [1:0] co = interface_control_lines_out;
    wire logic oe = interface_control_lines_oe;
    wire logic gnt = oe && co == plt_pkg::CODE_GRANT;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_grant; $rose(grant_busy) |-> $past(grant_req) && gnt; endproperty
    a_grant: assert property (p_grant) else $error("grant without request");
    property p_gidle; gnt |=> oe && co == plt_pkg::CODE_IDLE; endproperty
    a_gidle: assert property (p_gidle) else $error("grant not one cycle");
    property p_float; gnt |=> ##1 !oe && !data_lines_oe; endproperty
    a_float: assert property (p_float) else $error("lines still driven");
    property p_listen; link_owner |-> !oe && !data_lines_oe; endproperty
    a_listen: assert property (p_listen) else $error("driving while link owns");
    property p_regain; $rose(oe) |-> co == plt_pkg::CODE_IDLE; endproperty
    a_regain: assert property (p_regain) else $error("no idle on regain");
    property p_tx; tx_valid |-> $past(ci, 3) == plt_pkg::CODE_TX
        && tx_data == $past(data_lines_in, 3);
    endproperty
    a_tx: assert property (p_tx) else $error("transmit byte mismatch");
    property p_start; tx_start |-> tx_valid && $past(ci, 4) != plt_pkg::CODE_TX; endproperty
    a_start: assert property (p_start) else $error("bad start pulse");
    property p_term; concat_req || bus_release |-> !(concat_req && bus_release)
        && $past(ci, 3) == (concat_req ? plt_pkg::CODE_HOLD : plt_pkg::CODE_IDLE); endproperty
    a_term: assert property (p_term) else $error("bad termination");
endmodule : plt_phy_tx_props
bind plt_phy_tx plt_phy_tx_props u_props (.*);

// file: sim/plt_link_model.sv
`timescale 1ns/1ns
// ==========
// Link side of the transmit interface
module plt_link_model (
    input wire logic core_clk,
    input wire logic [1:0] code_wire,
    input wire logic phy_oe,
    input wire logic [3:0] lead,
    input wire logic [3:0] holds,
    input wire logic [3:0] nb,
    input wire logic th,
    input wire logic [7:0] sc,
    output logic [1:0] code,
    output logic [7:0] dat
);
    task automatic put(input logic [1:0] c, input logic [7:0] d);
        @(negedge core_clk);
        code = c;
        dat = d;
    endtask : put
    initial begin
        code = 2'h3;
        dat = 8'hFF;
        forever begin
            @(posedge core_clk);
            if (phy_oe === 1'b1 && code_wire === plt_pkg::CODE_GRANT) begin
                @(posedge core_clk);
                for (int i = 0; i < lead; i++) put(plt_pkg::CODE_IDLE, 8'h00);
                for (int i = 0; i < holds; i++) put(plt_pkg::CODE_HOLD, 8'h00);
                if (nb == 4'h0) begin
                    // Three idles when no hold, so the wire never floats early
                    for (int i = 0; i < (holds == 0 ? 3 - int'(lead) : 2); i++) begin
                        put(plt_pkg::CODE_IDLE, 8'h00);
                    end
                end else begin
                    for (int i = 0; i < nb; i++) put(plt_pkg::CODE_TX, 8'(8'hA0 + i));
                    put(th ? plt_pkg::CODE_HOLD : plt_pkg::CODE_IDLE,
                        th ? sc : 8'h00);
                    put(plt_pkg::CODE_IDLE, 8'h00);
                end
                // Released lines: no keeper, show the inverse of the last value
                put(~code, ~dat);
            end
        end
    end
endmodule : plt_link_model

// file: sim/test_plt_phy_tx.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin failures++; \
    $display("Error %s expected %0h seen %0h", n, e, s); end end
module test_plt_phy_tx;
    logic core_clk, interface_control_lines_oe, data_lines_oe, grant_busy, link_owner;
    logic tx_start, tx_valid, concat_req, bus_release, tx_cancel, proto_err, multispeed_concat_enable;
    logic [1:0] first_speed, interface_control_lines_in, interface_control_lines_out, tx_speed;
    logic [1:0] lk_code;
    logic [7:0] data_lines_in, data_lines_out, tx_data, lk_dat;
    logic sys_rst = 1'b1;
    logic grant_req = 1'b0;
    logic [39:0] row = '0;
    int failures = 0;
    int check_count = 0;
    // ==========
    // Rows, one digit a field: lead holds bytes hold-term code(2) enable speed outcome speed
    localparam logic [39:0] ROWS [10] = '{40'h0030000141, 40'h1411501082, 40'h02214A1081,
        40'h0011500181, 40'h0000000061, 40'h1000000060, 40'h0400000060, 40'h01113F1212,
        40'h0510000012, 40'h2110000012};
    // Rows after a terminating hold get a new grant but keep its speed
    assign multispeed_concat_enable = row[12];
    assign first_speed = row[9:8];
    assign interface_control_lines_in = interface_control_lines_oe ? interface_control_lines_out
                                                                   : lk_code;
    assign data_lines_in = data_lines_oe ? data_lines_out : lk_dat;
    plt_phy_tx #(.HOLD_LIMIT(4)) u_dut (.*);
    plt_link_model u_link (.core_clk, .code_wire(interface_control_lines_in),
        .phy_oe(interface_control_lines_oe), .lead(row[39:36]), .holds(row[35:32]),
        .nb(row[31:28]), .th(row[24]), .sc(row[23:16]), .code(lk_code), .dat(lk_dat));
    task automatic conclude();
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    task automatic start(input logic [39:0] r);
        @(negedge core_clk);
        row = r;
        grant_req = 1'b1;
        @(negedge core_clk);
        grant_req = 1'b0;
    endtask : start
    task automatic run_row(input logic [39:0] r);
        int nv, ns, owned, quiet;
        logic [3:0] seen;
        nv = 0;
        ns = 0;
        owned = 0;
        quiet = 0;
        seen = 4'h0;
        start(r);
        for (int t = 0; t < 200 && quiet < 8; t++) begin
            @(negedge core_clk);
            if (tx_valid === 1'b1) begin
                `CHK("tx_data", 8'(8'hA0 + nv), tx_data)
                nv++;
            end
            ns += int'(tx_start === 1'b1);
            seen = seen | {concat_req, bus_release, tx_cancel, proto_err};
            owned = owned | int'(link_owner === 1'b1);
            quiet += int'(owned != 0 && link_owner === 1'b0);
        end
        if (quiet < 8) begin
            failures++;
            conclude();
        end
        `CHK("proto_err", r[4], seen[0])
        if (r[4] === 1'b0) begin
            `CHK("outcome", r[7:5], seen[3:1])
            `CHK("tx_count", int'(r[31:28]), nv)
            `CHK("tx_start", int'(r[31:28] != 0), ns)
        end
        `CHK("tx_speed", r[1:0], tx_speed)
    endtask : run_row
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        repeat (10) @(negedge core_clk);
        sys_rst = 1'b0;
        // Faulty rows run last so a confused state cannot hide later checks
        for (int i = 0; i < 10; i++) run_row(ROWS[i]);
        start(ROWS[1]);
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b1;
        @(negedge core_clk);
        `CHK("code_out", plt_pkg::CODE_IDLE, interface_control_lines_out)
        `CHK("data_out", 8'h00, data_lines_out)
        `CHK("ctl_oe", 1'b1, interface_control_lines_oe)
        `CHK("owner", 1'b0, link_owner)
        sys_rst = 1'b0;
        repeat (30) @(negedge core_clk);
        run_row(ROWS[0]);
        conclude();
    end
endmodule : test_plt_phy_tx
